// File: sws_dev.sv
// Device end: reset/presence answer, slot sampling, read reply, programming interval
`timescale 1ns/1ps
`default_nettype none
module sws_dev
   import sws_pkg::*;
#(
   parameter sws_cnt_t RST_DET_STD = RST_LOW_STD_CYC,
   parameter sws_cnt_t PROG_LEN    = PROG_CYC
) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic overdrive,
   input  wire logic tx_valid,
   input  wire logic tx_bit,
   output logic      tx_ready,
   output logic      rx_valid,
   output logic      rx_bit,
   output logic      reset_seen,
   input  wire logic prog_req,
   output logic      prog_busy,
   sws_if.dev        bus
);
   typedef enum logic [2:0] {D_PRES_WAIT, D_PRES_LOW, D_IDLE, D_SLOT, D_RST, D_PROG} sws_dev_e;

   // ==========================================================
   // Line input filter
   logic s1_r, s2_r, s3_r, line_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1_r   <= 1'b1;
         s2_r   <= 1'b1;
         s3_r   <= 1'b1;
         line_r <= 1'b1;
      end else begin
         s1_r <= bus.dev_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            line_r <= s3_r;
         end
      end
   end

   // ==========================================================
   // Speed-dependent lengths
   wire sws_cnt_t pres_wait = overdrive ? PRES_WAIT_OD_CYC : PRES_WAIT_STD_CYC;
   wire sws_cnt_t pres_low  = overdrive ? PRES_LOW_OD_CYC : PRES_LOW_STD_CYC;
   wire sws_cnt_t smp_pt    = overdrive ? DEV_SMP_OD_CYC : DEV_SMP_STD_CYC;
   wire sws_cnt_t rd_hold   = overdrive ? READ_SMP_OD_CYC : READ_SMP_STD_CYC;
   wire sws_cnt_t rst_det   = (overdrive ? RST_LOW_OD_CYC : RST_DET_STD) - RST_DET_SLACK_CYC;
   wire sws_cnt_t ho_min    = overdrive ? HOLDOFF_OD_CYC : HOLDOFF_STD_CYC;
   wire sws_cnt_t ho_max    = overdrive ? HOLDOFF_OD_CYC : HOLDOFF_MAX_CYC;

   sws_dev_e st_r, st_nxt;
   sws_cnt_t cnt_r, cnt_nxt, ho_r;
   logic     drive_r, drive_nxt, rxv_nxt, rxb_nxt, rst_nxt, arm_r, slot_seen_r;

   wire fall_ok = !line_r && (ho_r >= ho_min);
   wire prog_go = arm_r && slot_seen_r && line_r && (ho_r == ho_max);
   assign tx_ready = (st_r == D_IDLE) && fall_ok && !prog_go;

   // ==========================================================
   // Slot state machine
   always_comb begin
      st_nxt    = st_r;
      cnt_nxt   = CW'(cnt_r + 1'b1);
      drive_nxt = drive_r;
      rxv_nxt   = 1'b0;
      rxb_nxt   = rx_bit;
      rst_nxt   = 1'b0;
      case (st_r)
         D_PRES_WAIT: begin
            if (cnt_r >= pres_wait - 1'b1) begin
               st_nxt    = D_PRES_LOW;
               cnt_nxt   = '0;
               drive_nxt = 1'b1;
            end
         end
         D_PRES_LOW: begin
            if (cnt_r >= pres_low - 1'b1) begin
               drive_nxt = 1'b0;
            end
            // Own pulse must read high again, or it looks like a slot start
            if (!drive_r && line_r) begin
               st_nxt = D_IDLE;
            end
         end
         D_IDLE: begin
            cnt_nxt = '0;
            if (prog_go) begin
               st_nxt = D_PROG;
            end else if (fall_ok) begin
               st_nxt    = D_SLOT;
               drive_nxt = tx_valid && !tx_bit;
            end
         end
         D_SLOT: begin
            if (drive_r && cnt_r >= rd_hold - 1'b1) begin
               drive_nxt = 1'b0;
            end
            if (cnt_r == smp_pt) begin
               rxv_nxt = 1'b1;
               rxb_nxt = line_r;
            end
            if (prog_go) begin
               st_nxt    = D_PROG;
               cnt_nxt   = '0;
               drive_nxt = 1'b0;
            end else if (!line_r && cnt_r >= rst_det) begin
               st_nxt    = D_RST;
               drive_nxt = 1'b0;
            end else if (line_r && cnt_r > smp_pt) begin
               st_nxt = D_IDLE;
            end
         end
         D_RST: begin
            if (line_r) begin
               st_nxt  = D_PRES_WAIT;
               cnt_nxt = '0;
               rst_nxt = 1'b1;
            end
         end
         D_PROG: begin
            if (cnt_r >= PROG_LEN - 1'b1) begin
               st_nxt = D_IDLE;
            end
         end
         default: begin
            st_nxt    = D_IDLE;
            drive_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r       <= D_PRES_WAIT;
         cnt_r      <= '0;
         drive_r    <= 1'b0;
         rx_valid   <= 1'b0;
         rx_bit     <= 1'b0;
         reset_seen <= 1'b0;
      end else begin
         st_r       <= st_nxt;
         cnt_r      <= cnt_nxt;
         drive_r    <= drive_nxt;
         rx_valid   <= rxv_nxt;
         rx_bit     <= rxb_nxt;
         reset_seen <= rst_nxt;
      end
   end

   // Hold-off counts high time since the last rise; arm waits for the closing rise
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ho_r        <= '0;
         arm_r       <= 1'b0;
         slot_seen_r <= 1'b0;
         prog_busy   <= 1'b0;
      end else begin
         ho_r      <= !line_r ? '0 : (ho_r == HOLDOFF_MAX_CYC ? ho_r : CW'(ho_r + 1'b1));
         arm_r     <= prog_req | (arm_r & ~prog_go);
         // Only the rise that closes a slot after arming may start programming
         slot_seen_r <= arm_r & ~prog_go & (slot_seen_r | ~line_r);
         prog_busy <= (st_nxt == D_PROG);
      end
   end

   assign bus.dev_out  = 1'b0;
   assign bus.dev_oe_n = ~drive_r;
endmodule
`default_nettype wire

// File: sws_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
`default_nettype none
module sws_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wptr_r;
   logic [AW:0]      rptr_r;
   wire              push = in_valid & in_ready;
   wire              pop  = out_valid & out_ready;

   assign in_ready  = (wptr_r - rptr_r) != (AW+1)'(DEPTH);
   assign out_valid = wptr_r != rptr_r;
   assign out_data  = mem_r[rptr_r[AW-1:0]];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wptr_r <= '0;
         rptr_r <= '0;
      end else begin
         if (push) begin
            wptr_r <= wptr_r + 1'b1;
         end
         if (pop) begin
            rptr_r <= rptr_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wptr_r[AW-1:0]] <= in_data;
      end
   end
endmodule
`default_nettype wire

// File: sws_host.sv
// Bus controller end: queued reset, write and read slots on the single-wire line
`timescale 1ns/1ps
`default_nettype none
module sws_host
   import sws_pkg::*;
#(
   parameter sws_cnt_t QUIET_LEN   = PWRUP_QUIET_CYC,
   parameter sws_cnt_t RST_LOW_STD = RST_LOW_STD_CYC,
   parameter int       DEPTH       = 8
) (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       overdrive,
   input  wire logic       cmd_valid,
   input  wire logic [1:0] cmd_op,
   output logic            cmd_ready,
   output logic            rsp_valid,
   output logic            rsp_bit,
   output logic            busy,
   sws_if.host             bus
);
   typedef enum logic [2:0] {H_QUIET, H_IDLE, H_RST_LOW, H_RST_REL, H_LOW, H_REL} sws_host_e;

   // ==========================================================
   // Line input filter
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic line_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1_r   <= 1'b1;
         s2_r   <= 1'b1;
         s3_r   <= 1'b1;
         line_r <= 1'b1;
      end else begin
         s1_r <= bus.host_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            line_r <= s3_r;
         end
      end
   end

   // ==========================================================
   // Command queue
   logic       q_valid;
   logic       q_take;
   logic [1:0] q_op;

   sws_fifo #(
      .WIDTH (2),
      .DEPTH (DEPTH)
   ) u_cmd_fifo (
      .clk       (clk),
      .resetn    (resetn),
      .in_valid  (cmd_valid),
      .in_ready  (cmd_ready),
      .in_data   (cmd_op),
      .out_valid (q_valid),
      .out_ready (q_take),
      .out_data  (q_op)
   );

   // ==========================================================
   // Speed-dependent lengths
   sws_host_e  st_r;
   sws_host_e  st_nxt;
   sws_cnt_t   cnt_r;
   sws_cnt_t   cnt_nxt;
   logic [1:0] op_r;
   logic [1:0] op_nxt;
   logic       drive_r;
   logic       drive_nxt;
   logic       bit_nxt;
   logic       rsp_nxt;

   wire sws_cnt_t rst_low  = overdrive ? RST_LOW_OD_CYC : RST_LOW_STD;
   wire sws_cnt_t pres_smp = overdrive ? PRES_SMP_OD_CYC : PRES_SMP_STD_CYC;
   wire sws_cnt_t pres_end = overdrive ? PRES_END_OD_CYC : PRES_END_STD_CYC;
   wire sws_cnt_t zero_low = overdrive ? ZERO_LOW_OD_CYC : ZERO_LOW_STD_CYC;
   wire sws_cnt_t read_low = overdrive ? READ_LOW_OD_CYC : READ_LOW_STD_CYC;
   wire sws_cnt_t read_smp = overdrive ? READ_SMP_OD_CYC : READ_SMP_STD_CYC;
   wire sws_cnt_t slot_len = overdrive ? SLOT_OD_CYC : SLOT_STD_CYC;

   wire is_wr0   = (op_r == SWS_OP_WR0);
   wire is_wr1   = (op_r == SWS_OP_WR1);
   wire is_read  = (op_r == SWS_OP_READ);
   wire q_reset  = (q_op == SWS_OP_RESET);
   wire low_done = is_wr0 ? (cnt_r >= zero_low - 1'b1) :
                   is_wr1 ? (cnt_r >= ONE_LOW_CYC - 1'b1) :
                            (cnt_r >= read_low - 1'b1);
   wire slot_done = line_r && (cnt_r >= slot_len - 1'b1);
   wire pres_done = line_r && (cnt_r >= pres_end);

   assign q_take = (st_r == H_IDLE) && q_valid;
   assign busy   = (st_r != H_IDLE) || q_valid;

   // ==========================================================
   // Slot sequencer
   always_comb begin
      st_nxt    = st_r;
      cnt_nxt   = CW'(cnt_r + 1'b1);
      op_nxt    = op_r;
      drive_nxt = drive_r;
      bit_nxt   = rsp_bit;
      rsp_nxt   = 1'b0;
      case (st_r)
         H_QUIET: begin
            if (cnt_r >= QUIET_LEN - 1'b1) begin
               st_nxt  = H_IDLE;
               cnt_nxt = '0;
            end
         end
         H_IDLE: begin
            cnt_nxt = '0;
            if (q_valid) begin
               op_nxt    = q_op;
               drive_nxt = 1'b1;
               st_nxt    = q_reset ? H_RST_LOW : H_LOW;
            end
         end
         H_RST_LOW: begin
            if (cnt_r >= rst_low - 1'b1) begin
               drive_nxt = 1'b0;
               cnt_nxt   = '0;
               st_nxt    = H_RST_REL;
            end
         end
         H_RST_REL: begin
            if (cnt_r == pres_smp) begin
               bit_nxt = ~line_r;
            end
            if (pres_done) begin
               rsp_nxt = 1'b1;
               st_nxt  = H_IDLE;
            end
         end
         H_LOW: begin
            if (low_done) begin
               drive_nxt = 1'b0;
               st_nxt    = H_REL;
            end
         end
         H_REL: begin
            if (is_read && cnt_r == read_smp) begin
               bit_nxt = line_r;
            end
            if (slot_done) begin
               rsp_nxt = is_read;
               st_nxt  = H_IDLE;
            end
         end
         default: begin
            drive_nxt = 1'b0;
            st_nxt    = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r    <= H_QUIET;
         cnt_r   <= '0;
         op_r    <= 2'h0;
         drive_r <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         cnt_r   <= cnt_nxt;
         op_r    <= op_nxt;
         drive_r <= drive_nxt;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rsp_valid <= 1'b0;
         rsp_bit   <= 1'b0;
      end else begin
         rsp_valid <= rsp_nxt;
         rsp_bit   <= bit_nxt;
      end
   end

   // ==========================================================
   // Open-drain pin: only ever drives low
   assign bus.host_out  = 1'b0;
   assign bus.host_oe_n = ~drive_r;
endmodule
`default_nettype wire

// File: sws_if.sv
// Open-drain single-wire line joining the bus controller and the device
`timescale 1ns/1ps
`default_nettype none
interface sws_if;
   logic host_in;
   logic host_out;
   logic host_oe_n;
   logic dev_in;
   logic dev_out;
   logic dev_oe_n;
   logic line;

   // Wired-AND with pull-up: low whenever an enabled driver drives low
   assign line    = (host_oe_n | host_out) & (dev_oe_n | dev_out);
   assign host_in = line;
   assign dev_in  = line;

   modport host (input host_in, output host_out, output host_oe_n);
   modport dev  (input dev_in, output dev_out, output dev_oe_n);
endinterface
`default_nettype wire

// File: sws_link_props.sv
// Line timing checker watching the single-wire link between host and device
`timescale 1ns/1ps
`default_nettype none
module sws_link_props
   import sws_pkg::*;
#(
   parameter int QUIET_LEN = 20000,
   parameter int RST_LOW   = 4800
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic overdrive,
   input wire logic host_oe_n,
   input wire logic dev_oe_n,
   input wire logic line
);
   // ==========================================
   // Run, gap and window counters
   int        hrun_r, drun_r, gap_r, rel_r, up_r;
   logic      hoe_q, doe_q, first_r, pend_r, win_r, pwr_r, sp_r;
   wire logic h_fall = hoe_q & ~host_oe_n;
   wire logic d_fall = doe_q & ~dev_oe_n;
   wire logic d_rise = ~doe_q & dev_oe_n;
   wire logic rst_lim = hrun_r >= (overdrive ? int'(RST_LOW_OD_CYC) : RST_LOW);
   wire logic long_rel = ~hoe_q & host_oe_n & rst_lim;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hoe_q <= 1'b1;
         doe_q <= 1'b1;
         hrun_r <= 0;
         drun_r <= 0;
         gap_r <= 0;
         rel_r <= 0;
         up_r <= 0;
         first_r <= 1'b1;
         pend_r <= 1'b0;
         win_r <= 1'b0;
         pwr_r <= 1'b1;
         sp_r <= 1'b0;
      end else begin
         hoe_q <= host_oe_n;
         doe_q <= dev_oe_n;
         hrun_r <= host_oe_n ? 0 : hrun_r + 1;
         drun_r <= dev_oe_n ? 0 : drun_r + 1;
         gap_r <= h_fall ? 1 : gap_r + 1;
         rel_r <= long_rel ? 1 : rel_r + 1;
         up_r <= up_r + 1;
         first_r <= first_r & ~h_fall;
         sp_r <= h_fall ? overdrive : sp_r;
         pend_r <= long_rel | (pend_r & ~d_fall);
         win_r <= long_rel | (win_r & ~h_fall);
         pwr_r <= pwr_r & ~d_rise;
      end
   end

   // ==========================================
   // Assertions
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   host_low_len_a : assert property (
      $rose(host_oe_n) |-> (overdrive ? hrun_r inside {[8:20], [60:155], [480:800]}
                            : (hrun_r inside {[10:150], [600:1200]} || hrun_r >= RST_LOW)))
      else $error("host low pulse length out of range");
   slot_gap_a : assert property (
      $fell(host_oe_n) && !first_r |-> gap_r >= (sp_r ? int'(SLOT_OD_CYC) : int'(SLOT_STD_CYC)))
      else $error("host slot shorter than minimum");
   quiet_start_a : assert property (
      $fell(host_oe_n) && first_r |-> gap_r >= QUIET_LEN)
      else $error("host drove line during power-up quiet");
   pres_wait_a : assert property (
      $fell(dev_oe_n) && pend_r |-> (overdrive ? rel_r inside {[20:63]} : rel_r inside {[150:610]}))
      else $error("presence wait out of range");
   pres_window_a : assert property (
      win_r && (overdrive ? rel_r inside {[60:100]} : rel_r inside {[600:745]}) |-> !line && !dev_oe_n)
      else $error("line not low in presence sample window");
   dev_low_len_a : assert property (
      $rose(dev_oe_n) |-> (overdrive ? drun_r inside {[22:30], [80:240]}
                                     : drun_r inside {[150:160], [600:2400]}))
      else $error("device low pulse length out of range");
   pwrup_pres_a : assert property (
      $rose(dev_oe_n) && pwr_r |-> up_r <= int'(PWRUP_QUIET_CYC))
      else $error("power-up presence not finished in time");
   dev_cause_a : assert property (
      $fell(dev_oe_n) |-> pend_r || pwr_r || !host_oe_n)
      else $error("device drove line without a slot");
endmodule
`default_nettype wire

// File: sws_pkg.sv
// Shared timing constants and command codes for the single-wire slot timing link
package sws_pkg;

   // ==========================================================
   // Clock and counter width
   localparam int CLK_NS = 100;
   localparam int CW     = 17;
   typedef logic [CW-1:0] sws_cnt_t;

   // ==========================================================
   // Line times in ns
   localparam int RST_LOW_STD_MIN_NS  = 480000;
   localparam int RST_LOW_OD_MIN_NS   = 48000;
   localparam int PRES_SMP_STD_MIN_NS = 60000;
   localparam int PRES_SMP_STD_MAX_NS = 75000;
   localparam int PRES_SMP_OD_MIN_NS  = 6000;
   localparam int PRES_SMP_OD_MAX_NS  = 10000;
   localparam int PRES_WAIT_STD_MIN_NS = 15000;
   localparam int PRES_WAIT_STD_MAX_NS = 60000;
   localparam int PRES_WAIT_OD_MIN_NS  = 2000;
   localparam int PRES_WAIT_OD_MAX_NS  = 6000;
   localparam int PRES_LOW_STD_MIN_NS  = 60000;
   localparam int PRES_LOW_STD_MAX_NS  = 240000;
   localparam int PRES_LOW_OD_MIN_NS   = 8000;
   localparam int PRES_LOW_OD_MAX_NS   = 24000;
   localparam int ZERO_LOW_STD_MIN_NS  = 60000;
   localparam int ZERO_LOW_OD_MIN_NS   = 6000;
   localparam int ONE_LOW_MIN_NS       = 1000;
   localparam int ONE_LOW_STD_MAX_NS   = 15000;
   localparam int ONE_LOW_OD_MAX_NS    = 2000;
   localparam int READ_LOW_STD_MIN_NS  = 5000;
   localparam int READ_LOW_OD_MIN_NS   = 800;
   localparam int READ_SMP_STD_MAX_NS  = 15000;
   localparam int READ_SMP_OD_MAX_NS   = 2270;
   localparam int SLOT_STD_MIN_NS      = 65000;
   localparam int SLOT_OD_MIN_NS       = 11000;
   localparam int REC_STD_MIN_NS       = 5000;
   localparam int HOLDOFF_STD_MIN_NS   = 500;
   localparam int HOLDOFF_STD_MAX_NS   = 5000;
   localparam int HOLDOFF_OD_NS        = 0;
   localparam int PROG_MAX_NS          = 10000000;
   localparam int PWRUP_QUIET_NS       = 2000000;

   // ==========================================================
   // Cycle counts: least times round up (SLOT_STD_CYC truncates), longest times round down
   localparam sws_cnt_t RST_LOW_STD_CYC  = CW'((RST_LOW_STD_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam sws_cnt_t RST_LOW_OD_CYC   = CW'((RST_LOW_OD_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam sws_cnt_t PRES_SMP_STD_CYC = CW'((PRES_SMP_STD_MIN_NS + PRES_SMP_STD_MAX_NS) / 2 / CLK_NS);
   localparam sws_cnt_t PRES_SMP_OD_CYC  = CW'((PRES_SMP_OD_MIN_NS + PRES_SMP_OD_MAX_NS) / 2 / CLK_NS);
   localparam sws_cnt_t PRES_END_STD_CYC = CW'((PRES_WAIT_STD_MAX_NS + PRES_LOW_STD_MAX_NS) / CLK_NS);
   localparam sws_cnt_t PRES_END_OD_CYC  = CW'((PRES_WAIT_OD_MAX_NS + PRES_LOW_OD_MAX_NS) / CLK_NS);
   localparam sws_cnt_t PRES_WAIT_STD_CYC = CW'((PRES_WAIT_STD_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam sws_cnt_t PRES_WAIT_OD_CYC  = CW'((PRES_WAIT_OD_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam sws_cnt_t PRES_LOW_STD_CYC  = CW'((PRES_LOW_STD_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam sws_cnt_t PRES_LOW_OD_CYC   = CW'((PRES_LOW_OD_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam sws_cnt_t ZERO_LOW_STD_CYC  = CW'((ZERO_LOW_STD_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam sws_cnt_t ZERO_LOW_OD_CYC   = CW'((ZERO_LOW_OD_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam sws_cnt_t ONE_LOW_CYC       = CW'((ONE_LOW_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam sws_cnt_t DEV_SMP_STD_CYC   = CW'((ONE_LOW_STD_MAX_NS + ZERO_LOW_STD_MIN_NS) / 2 / CLK_NS);
   localparam sws_cnt_t DEV_SMP_OD_CYC    = CW'((ONE_LOW_OD_MAX_NS + ZERO_LOW_OD_MIN_NS) / 2 / CLK_NS);
   localparam sws_cnt_t READ_LOW_STD_CYC  = CW'((READ_LOW_STD_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam sws_cnt_t READ_LOW_OD_CYC   = CW'((READ_LOW_OD_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam sws_cnt_t READ_SMP_STD_CYC  = CW'(READ_SMP_STD_MAX_NS / CLK_NS);
   localparam sws_cnt_t READ_SMP_OD_CYC   = CW'(READ_SMP_OD_MAX_NS / CLK_NS);
   localparam sws_cnt_t SLOT_STD_CYC = CW'(((SLOT_STD_MIN_NS > ZERO_LOW_STD_MIN_NS + REC_STD_MIN_NS) ?
                                        SLOT_STD_MIN_NS : ZERO_LOW_STD_MIN_NS + REC_STD_MIN_NS) / CLK_NS);
   localparam sws_cnt_t SLOT_OD_CYC       = CW'((SLOT_OD_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam sws_cnt_t HOLDOFF_STD_CYC   = CW'((HOLDOFF_STD_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam sws_cnt_t HOLDOFF_MAX_CYC   = CW'(HOLDOFF_STD_MAX_NS / CLK_NS);
   localparam sws_cnt_t HOLDOFF_OD_CYC    = CW'(HOLDOFF_OD_NS / CLK_NS);
   localparam sws_cnt_t PROG_CYC          = CW'(PROG_MAX_NS / CLK_NS);
   localparam sws_cnt_t PWRUP_QUIET_CYC   = CW'((PWRUP_QUIET_NS + CLK_NS - 1) / CLK_NS);
   // Reset is recognised this much short of its minimum: filter and slot entry delay
   localparam sws_cnt_t RST_DET_SLACK_CYC = CW'(8);

   // ==========================================================
   // Host command codes
   typedef enum logic [1:0] {SWS_OP_RESET, SWS_OP_WR0, SWS_OP_WR1, SWS_OP_READ} sws_op_e;

endpackage

// File: test_single_wire_slot_timing.sv
// Self-checking bench driving host commands and device bits across the link
`timescale 1ns/1ps
`default_nettype none
module test_single_wire_slot_timing
   import sws_pkg::*;
;
   localparam int QL = 800;
   localparam int RL = 700;
   localparam int PL = 40;
   logic       clk       = 1'b0;
   logic       resetn    = 1'b0;
   logic       overdrive = 1'b0;
   logic       cmd_valid = 1'b0;
   logic [1:0] cmd_op    = 2'h0;
   logic       tx_valid  = 1'b1;
   logic       tx_bit    = 1'b1;
   logic       prog_req  = 1'b0;
   logic       cmd_ready, rsp_valid, rsp_bit, busy;
   logic       tx_ready, rx_valid, rx_bit, reset_seen, prog_busy;
   int         err_count = 0;
   int         checks    = 0;
   int         n_rst     = 0;
   int         lh        = 0;
   int         lh_at     = 0;
   int         pb_len    = 0;
   int         n_tx      = 0;
   logic       rsp_q[$];
   logic       rx_q[$];
   sws_op_e    ops_q[$];
   sws_op_e    fill_q[$];

   sws_if sws_if_i ();
   sws_host #(.QUIET_LEN(sws_cnt_t'(QL)), .RST_LOW_STD(sws_cnt_t'(RL)), .DEPTH(8)) sws_host_i (
      .clk(clk), .resetn(resetn), .overdrive(overdrive), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_bit(rsp_bit), .busy(busy), .bus(sws_if_i));
   sws_dev #(.RST_DET_STD(sws_cnt_t'(650)), .PROG_LEN(sws_cnt_t'(PL))) sws_dev_i (
      .clk(clk), .resetn(resetn), .overdrive(overdrive), .tx_valid(tx_valid), .tx_bit(tx_bit),
      .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_bit(rx_bit), .reset_seen(reset_seen),
      .prog_req(prog_req), .prog_busy(prog_busy), .bus(sws_if_i));
   sws_link_props #(.QUIET_LEN(QL), .RST_LOW(RL)) sws_link_props_i (
      .clk(clk), .resetn(resetn), .overdrive(overdrive), .host_oe_n(sws_if_i.host_oe_n),
      .dev_oe_n(sws_if_i.dev_oe_n), .line(sws_if_i.line));

   always #50 clk = ~clk;

   // ==========================================
   // Answer collection
   always @(posedge clk) begin
      if (rsp_valid === 1'b1) rsp_q.push_back(rsp_bit);
      if (rx_valid === 1'b1) rx_q.push_back(rx_bit);
      if (reset_seen === 1'b1) n_rst++;
      if (tx_ready === 1'b1) n_tx++;
      if (prog_busy === 1'b1) begin
         if (pb_len == 0) lh_at = lh;
         pb_len++;
      end
      lh = (sws_if_i.line === 1'b1) ? lh + 1 : 0;
   end

   // ==========================================
   // Tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Mode 1 also tries a ninth push on a full queue; mode 2 skips answer checks
   task automatic run(input int mode);
      logic er[$];
      logic ex[$];
      int   r0;
      int   n;
      int   t0;
      r0 = n_rst;
      t0 = n_tx;
      n = 0;
      rsp_q = {};
      rx_q = {};
      foreach (ops_q[i]) begin
         while (cmd_ready !== 1'b1) begin
            @(posedge clk);
            #10;
         end
         cmd_valid = 1'b1;
         cmd_op = ops_q[i];
         if (ops_q[i] == SWS_OP_RESET) begin
            er.push_back(1'b1);
            r0++;
         end
         // Mid-slot sample: low through a zero write or a reset, high otherwise
         ex.push_back(ops_q[i] inside {SWS_OP_WR1, SWS_OP_READ});
         if (ops_q[i] == SWS_OP_READ) er.push_back(tx_bit);
         @(posedge clk);
         #10;
      end
      if (mode == 1) begin
         chk("cmd_ready when full", 0, cmd_ready);
         cmd_op = SWS_OP_READ;
         @(posedge clk);
         #10;
      end
      cmd_valid = 1'b0;
      while (busy !== 1'b0 && n < 20000) begin
         @(posedge clk);
         #10;
         n++;
      end
      chk("idle reached", 1, n < 20000);
      repeat (20) @(posedge clk);
      #10;
      if (mode != 2) begin
         chk("rsp count", er.size(), rsp_q.size());
         chk("rx count", ex.size(), rx_q.size());
         chk("tx_ready count", ops_q.size(), n_tx - t0);
         chk("reset_seen count", r0, n_rst);
         foreach (er[i]) if (i < rsp_q.size()) chk("rsp_bit", er[i], rsp_q[i]);
         foreach (ex[i]) if (i < rx_q.size()) chk("rx_bit", ex[i], rx_q[i]);
      end
   endtask

   // ==========================================
   // Sequence
   initial begin
      fill_q = {SWS_OP_RESET, SWS_OP_WR0, SWS_OP_WR1, SWS_OP_READ,
                SWS_OP_WR1, SWS_OP_WR0, SWS_OP_READ, SWS_OP_RESET};
      repeat (2) @(posedge clk);
      #10;
      resetn = 1'b1;
      ops_q = fill_q;
      run(1);
      tx_bit = 1'b0;
      ops_q = {SWS_OP_READ};
      run(0);
      tx_bit = 1'b1;
      overdrive = 1'b1;
      ops_q = fill_q;
      run(0);
      tx_bit = 1'b0;
      ops_q = {SWS_OP_READ};
      run(0);
      overdrive = 1'b0;
      tx_bit = 1'b1;
      prog_req = 1'b1;
      @(posedge clk);
      #10;
      prog_req = 1'b0;
      ops_q = {SWS_OP_WR1};
      run(2);
      chk("holdoff before programming", 1, lh_at >= HOLDOFF_MAX_CYC && lh_at <= HOLDOFF_MAX_CYC + 6);
      chk("programming length", PL, pb_len);
      tally_and_finish();
   end

   initial begin
      #(60000 * 100);
      err_count++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
